/* rtl/cc_register_bank.sv */
// Serial-access control register bank of the converter, with calibration trigger
//
// Behaviour
// [RL1] Register contents act only in extended control mode; pin mode ignores them.
// [RL2] Host writes 1C0Eh to bias register 6h above 1.6 GHz clock.
// [RL3] Four-bit address selects one of twelve registers; four addresses reserved.
// [RL4] Reset loads main configuration with 2000h, only output level bit set.
// [RL5] Writing calibration bit to one starts a calibration.
// [RL6] Hardware never clears the calibration bit after calibration.
// [RL7] Host writes bit zero then one to request another calibration.
// [RL8] Calibration request is calibration bit OR calibration pin.
// [RL9] Host keeps bit and pin low before raising either one.
// [RL10] In DDR mode bit 14 picks 0 or 90 degree data-to-clock phase.
// [RL11] Host always writes zero to reserved bit 9.
// [RL12] Writes to reserved addresses 1h, 8h, 9h, Fh change nothing.
`timescale 1ns/1ps
module cc_register_bank (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Serial register port
  input wire logic serial_clk,
  input wire logic serial_sel_n,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe,
  // Mode and control pins
  input wire logic extended_control_mode,
  input wire logic cal_pin,
  input wire logic pin_level_select,
  input wire logic pin_phase_select,
  // Settings applied to the converter
  output cc_pkg::cc_apply_t apply
);

  function automatic logic is_reserved(input logic [3:0] a);
    is_reserved = (a == cc_pkg::A_RESERVED_ONE) || (a == cc_pkg::A_RESERVED_EIGHT) ||
                  (a == cc_pkg::A_RESERVED_NINE) || (a == cc_pkg::A_RESERVED_FIFTEEN);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  logic [6:0] sync1;
  logic [6:0] sync2;
  logic sclk_d;
  logic sclk_s, sel_n_s, sdi_s, ecm_s, cal_pin_s, pin_level_s, pin_phase_s;
  logic clk_rise, clk_fall;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sync1 <= cc_pkg::SYNC_RST;
      sync2 <= cc_pkg::SYNC_RST;
      sclk_d <= 1'b0;
    end else begin
      sync1 <= {serial_clk, serial_sel_n, serial_in, extended_control_mode, cal_pin,
                pin_level_select, pin_phase_select};
      sync2 <= sync1;
      sclk_d <= sync2[6];
    end
  end

  assign {sclk_s, sel_n_s, sdi_s, ecm_s, cal_pin_s, pin_level_s, pin_phase_s} = sync2;
  assign clk_rise = sclk_s & ~sclk_d;
  assign clk_fall = ~sclk_s & sclk_d;

  ////////////////////////////////////////////////////////////////////////////////
  // Serial frame receiver

  cc_pkg::cc_state_t state;
  logic [4:0] bit_cnt;
  logic [15:0] shift_in;
  cc_pkg::cc_hdr_t hdr;
  cc_pkg::cc_hdr_t hdr_next;
  logic [15:0] wr_data;
  logic hdr_done;
  logic wr_commit;

  assign hdr_next = cc_pkg::cc_hdr_t'({shift_in[6:0], sdi_s});
  assign wr_data = {shift_in[14:0], sdi_s};
  assign hdr_done = (state == cc_pkg::CC_HDR) && clk_rise && !sel_n_s &&
                    (bit_cnt == cc_pkg::HDR_BITS - 5'h01);
  assign wr_commit = (state == cc_pkg::CC_DATA) && clk_rise && !sel_n_s && !hdr.read &&
                     (bit_cnt == cc_pkg::FRAME_BITS - 5'h01);

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state <= cc_pkg::CC_IDLE;
      bit_cnt <= 5'h00;
      shift_in <= 16'h0000;
      hdr <= '0;
    end else begin
      case (state)
        cc_pkg::CC_IDLE: begin
          bit_cnt <= 5'h00;
          if (!sel_n_s) begin
            state <= cc_pkg::CC_HDR;
          end
        end
        cc_pkg::CC_HDR, cc_pkg::CC_DATA: begin
          if (sel_n_s) begin
            // A frame cut short is dropped with no write
            state <= cc_pkg::CC_IDLE;
          end else if (clk_rise) begin
            shift_in <= wr_data;
            bit_cnt <= bit_cnt + 5'h01;
            if (hdr_done) begin
              hdr <= hdr_next;
              state <= cc_pkg::CC_DATA;
            end else if (bit_cnt == cc_pkg::FRAME_BITS - 5'h01) begin
              state <= cc_pkg::CC_DONE;
            end
          end
        end
        default: begin
          // Extra clocks after the data word are ignored until deselect
          if (sel_n_s) begin
            state <= cc_pkg::CC_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register file

  logic [15:0][15:0] regs;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      regs <= '0;
      regs[cc_pkg::A_CONFIG] <= cc_pkg::CONFIG_RST; // RL4
    end else if (wr_commit && !is_reserved(hdr.addr)) begin // RL12
      // Besides reset, only a host write touches the calibration bit; calibration never clears it
      regs[hdr.addr] <= wr_data; // RL3 RL6
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read path: data leaves on falling serial clock so the host samples it on rising

  logic [15:0] rd_shift;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rd_shift <= 16'h0000;
      serial_out <= 1'b0;
      serial_out_oe <= 1'b0;
    end else begin
      serial_out_oe <= !sel_n_s && hdr.read &&
                       (state == cc_pkg::CC_DATA || state == cc_pkg::CC_DONE);
      if (hdr_done) begin
        rd_shift <= is_reserved(hdr_next.addr) ? cc_pkg::REG_RST : regs[hdr_next.addr]; // RL3
      end else if (state == cc_pkg::CC_DATA && hdr.read && clk_fall) begin
        serial_out <= rd_shift[15];
        rd_shift <= {rd_shift[14:0], 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Calibration request and applied settings

  logic cal_req;
  logic cal_req_q;

  assign cal_req = (ecm_s & regs[cc_pkg::A_CONFIG][cc_pkg::CAL_BIT]) | cal_pin_s; // RL8 RL1

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cal_req_q <= 1'b0;
      apply <= '0;
    end else begin
      cal_req_q <= cal_req;
      // Only a rising request starts a calibration; a level held high does not repeat
      apply.cal_start <= cal_req & ~cal_req_q; // RL5 RL8
      if (ecm_s) begin
        apply.phase_sel <= regs[cc_pkg::A_CONFIG][cc_pkg::PHASE_BIT] &
                           ~regs[cc_pkg::A_CONFIG][cc_pkg::SDR_BIT]; // RL10
        apply.level_sel <= regs[cc_pkg::A_CONFIG][cc_pkg::LEVEL_BIT];
        apply.bias <= regs[cc_pkg::A_BIAS];
      end else begin
        apply.phase_sel <= pin_phase_s; // RL1
        apply.level_sel <= pin_level_s;
        apply.bias <= cc_pkg::REG_RST;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  logic first_cycle;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      first_cycle <= 1'b1;
    end else begin
      first_cycle <= 1'b0;
    end
  end

  sequence s_req_rise;
    !cal_req ##1 cal_req;
  endsequence

  sequence s_start_pulse;
    apply.cal_start ##1 !apply.cal_start;
  endsequence

  a_config_reset_value: assert property (@(posedge clock) disable iff (sys_rst) // RL4
    first_cycle |-> regs[cc_pkg::A_CONFIG] == cc_pkg::CONFIG_RST)
    else $error("main configuration did not reset to 2000h");

  a_cal_start_once: assert property (@(posedge clock) disable iff (sys_rst) // RL5
    s_req_rise |=> s_start_pulse)
    else $error("rising calibration request did not give a single start pulse");

  a_cal_bit_kept: assert property (@(posedge clock) disable iff (sys_rst) // RL6
    regs[cc_pkg::A_CONFIG][cc_pkg::CAL_BIT] && !wr_commit
      |=> regs[cc_pkg::A_CONFIG][cc_pkg::CAL_BIT])
    else $error("calibration bit cleared without a host write");

  a_cal_pin_or: assert property (@(posedge clock) disable iff (sys_rst) // RL8
    (!ecm_s && $rose(cal_pin_s) && !$past(cal_req)) |=> apply.cal_start)
    else $error("calibration pin did not start a calibration");

  a_pin_mode_cal: assert property (@(posedge clock) disable iff (sys_rst) // RL1
    (!ecm_s && !cal_pin_s) |=> !apply.cal_start)
    else $error("register bit started calibration in pin mode");

  a_pin_mode_level: assert property (@(posedge clock) disable iff (sys_rst) // RL1
    !ecm_s |=> apply.level_sel == $past(pin_level_s) && apply.bias == cc_pkg::REG_RST)
    else $error("register value applied in pin mode");

  a_phase_select: assert property (@(posedge clock) disable iff (sys_rst) // RL10
    ecm_s |=> apply.phase_sel == $past(regs[cc_pkg::A_CONFIG][cc_pkg::PHASE_BIT] &
                                      ~regs[cc_pkg::A_CONFIG][cc_pkg::SDR_BIT]))
    else $error("phase select does not follow bit 14 in DDR mode");

  a_write_decode: assert property (@(posedge clock) disable iff (sys_rst) // RL3
    (wr_commit && !is_reserved(hdr.addr)) |=> regs[$past(hdr.addr)] == $past(wr_data))
    else $error("write did not reach the addressed register");

  a_reserved_write: assert property (@(posedge clock) disable iff (sys_rst) // RL12
    (wr_commit && is_reserved(hdr.addr)) |=> $stable(regs))
    else $error("write to reserved address changed a register");

endmodule

/* rtl/cc_pkg.sv */
// Constants, field positions and carrier types of the converter control register bank
package cc_pkg;
  // Register addresses
  localparam logic [3:0] A_CONFIG = 4'h0;
  localparam logic [3:0] A_RESERVED_ONE = 4'h1;
  localparam logic [3:0] A_FIRST_OFFSET = 4'h2;
  localparam logic [3:0] A_FIRST_FULL_SCALE = 4'h3;
  localparam logic [3:0] A_CAL_ADJUST = 4'h4;
  localparam logic [3:0] A_CAL_VALUES = 4'h5;
  localparam logic [3:0] A_BIAS = 4'h6;
  localparam logic [3:0] A_DUAL_EDGE_TIMING = 4'h7;
  localparam logic [3:0] A_RESERVED_EIGHT = 4'h8;
  localparam logic [3:0] A_RESERVED_NINE = 4'h9;
  localparam logic [3:0] A_SECOND_OFFSET = 4'ha;
  localparam logic [3:0] A_SECOND_FULL_SCALE = 4'hb;
  localparam logic [3:0] A_APERTURE_COARSE = 4'hc;
  localparam logic [3:0] A_APERTURE_FINE = 4'hd;
  localparam logic [3:0] A_AUTO_SYNC = 4'he;
  localparam logic [3:0] A_RESERVED_FIFTEEN = 4'hf;
  // Reset values
  localparam logic [15:0] CONFIG_RST = 16'h2000;
  localparam logic [15:0] REG_RST = 16'h0000;
  // Fields of main_configuration
  localparam int CAL_BIT = 15;
  localparam int PHASE_BIT = 14;
  localparam int LEVEL_BIT = 13;
  localparam int SDR_BIT = 2;
  // Serial frame: 8 header bits then 16 data bits, most significant first
  localparam logic [4:0] HDR_BITS = 5'h08;
  localparam logic [4:0] FRAME_BITS = 5'h18;
  // Input synchroniser reset image: select idles high
  localparam logic [6:0] SYNC_RST = 7'h20;

  typedef struct packed {
    logic read;
    logic [2:0] pad;
    logic [3:0] addr;
  } cc_hdr_t;

  typedef struct packed {
    logic cal_start;
    logic phase_sel;
    logic level_sel;
    logic [15:0] bias;
  } cc_apply_t;

  typedef enum logic [1:0] {
    CC_IDLE = 2'b00,
    CC_HDR = 2'b01,
    CC_DATA = 2'b10,
    CC_DONE = 2'b11
  } cc_state_t;
endpackage

/* verification/cc_host_model.sv */
// Host-side model that drives the serial register port
`timescale 1ns/1ps
module cc_host_model (
  // Serial register port
  output logic serial_clk,
  output logic serial_sel_n,
  output logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe
);
  localparam time HALF = 80ns;

  initial begin
    serial_clk = 1'b0;
    serial_sel_n = 1'b1;
    serial_in = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One 24-bit frame; the link clock stands low outside frames
  task automatic frame(input logic rd, input logic [3:0] addr, input logic [15:0] wdata,
                       output logic [15:0] rdata, output logic oe_ok);
    logic [23:0] bits;
    bits = {rd, 3'h5, addr, rd ? 16'h0000 : wdata};
    rdata = 16'h0000;
    oe_ok = 1'b1;
    // Pins change by non-blocking assignment so the block's sampling edge sees no race
    serial_sel_n <= 1'b0;
    #(HALF);
    for (int i = 23; i >= 0; i--) begin
      serial_in <= bits[i];
      #(HALF);
      if (rd && i < 16) begin
        rdata[i] = serial_out;
        oe_ok &= serial_out_oe;
      end
      serial_clk <= 1'b1;
      #(HALF);
      serial_clk <= 1'b0;
    end
    // Released data line shows the inverse so a stale bit cannot pass
    serial_in <= ~serial_in;
    #(HALF);
    serial_sel_n <= 1'b1;
    #(HALF);
  endtask
endmodule

/* verification/converter_control_register_map_tb.sv */
// Self-checking testbench of the converter control register bank
`timescale 1ns/1ps
module converter_control_register_map_tb;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic serial_clk, serial_sel_n, serial_in, serial_out, serial_out_oe;
  logic extended_control_mode = 1'b1;
  logic cal_pin = 1'b0;
  logic pin_level_select = 1'b0;
  logic pin_phase_select = 1'b0;
  cc_pkg::cc_apply_t apply;
  int err_count = 0;
  int num_checks = 0;
  int pulses = 0;
  int cycles = 0;
  int mdl [16];
  logic [15:0] rd;
  logic oe_ok;

  always #5 clock = ~clock;

  cc_register_bank dut (.clock(clock), .sys_rst(sys_rst), .serial_clk(serial_clk),
    .serial_sel_n(serial_sel_n), .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .extended_control_mode(extended_control_mode),
    .cal_pin(cal_pin), .pin_level_select(pin_level_select),
    .pin_phase_select(pin_phase_select), .apply(apply));

  cc_host_model host (.serial_clk(serial_clk), .serial_sel_n(serial_sel_n),
    .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe));

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (apply.cal_start === 1'b1) pulses <= pulses + 1;
    if (cycles == 40000) begin
      err_count++;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [18:0] seen, input logic [18:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  function automatic logic rsv(input logic [3:0] a);
    return a == 4'h1 || a == 4'h8 || a == 4'h9 || a == 4'hf;
  endfunction

  function automatic logic [18:0] exp_apply();
    logic [15:0] c;
    c = 16'(mdl[0]);
    if (extended_control_mode) return {1'b0, c[14] & ~c[2], c[13], 16'(mdl[6])};
    return {1'b0, pin_phase_select, pin_level_select, 16'h0000};
  endfunction

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    host.frame(1'b0, a, d, rd, oe_ok);
    mdl[a] = rsv(a) ? 0 : int'(d);
  endtask

  task automatic rdchk(input logic [3:0] a);
    host.frame(1'b1, a, 16'h0000, rd, oe_ok);
    check(19'(rd), 19'(mdl[a]));
    check(19'(oe_ok), 19'h00001);
  endtask

  // Write main configuration, then count calibration pulses
  task automatic calchk(input logic [15:0] d, input int n);
    int p0;
    p0 = pulses;
    wr(4'h0, d);
    repeat (10) @(posedge clock);
    check(19'(pulses - p0), 19'(n));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [3:0] k;
    void'($urandom(32'hcfe1f5da));
    foreach (mdl[i]) mdl[i] = 0;
    mdl[0] = 16'h2000;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (5) @(posedge clock);
    rdchk(4'h0);
    check(apply, exp_apply());
    $display("test reset done");
    // Random fill with reserved bit 9 and the trigger kept low
    for (int a = 1; a < 16; a++) wr(4'(a), 16'($urandom));
    wr(4'h0, 16'($urandom) & 16'h3dff);
    for (int a = 0; a < 16; a++) rdchk(4'(a));
    $display("test address map done");
    wr(4'h6, 16'h1c0e);
    for (int m = 0; m < 16; m++) begin
      k = 4'(m);
      wr(4'h0, {1'b0, k[3], k[2], 10'h000, k[1], 2'b00});
      @(posedge clock);
      extended_control_mode <= k[0];
      pin_level_select <= ~k[2];
      pin_phase_select <= k[1];
      repeat (6) @(posedge clock);
      check(apply, exp_apply());
    end
    $display("test mode and phase done");
    extended_control_mode <= 1'b1;
    calchk(16'h0000, 0);
    calchk(16'h8000, 1);
    rdchk(4'h0);
    calchk(16'h8000, 0);
    calchk(16'h0000, 0);
    calchk(16'h8000, 1);
    calchk(16'h0000, 0);
    cal_pin <= 1'b1;
    repeat (10) @(posedge clock);
    check(19'(pulses), 19'h00003);
    calchk(16'h8000, 0);
    cal_pin <= 1'b0;
    calchk(16'h0000, 0);
    extended_control_mode <= 1'b0;
    calchk(16'h8000, 0);
    calchk(16'h0000, 0);
    cal_pin <= 1'b1;
    repeat (10) @(posedge clock);
    check(19'(pulses), 19'h00004);
    cal_pin <= 1'b0;
    $display("test calibration done");
    // Second reset in mid-run brings every register back to its reset value
    repeat (3) @(posedge clock);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    foreach (mdl[i]) mdl[i] = 0;
    mdl[0] = 16'h2000;
    repeat (5) @(posedge clock);
    rdchk(4'h0);
    rdchk(4'h6);
    check(apply, exp_apply());
    check(19'(serial_out_oe), 19'h00000);
    $display("test second reset done");
    wrap_up();
  end
endmodule
